//--- src/hcp_map.vh
// Purpose: constants for the host command and power control block
// Assumes: 20 MHz clk, 8-bit registers, 5-bit register address
// Notes: register offsets are register indices on the host port
// How it works
// - auto-reset releases after 35000 times reset capacitance once supplies are valid; the code counts RC_CYC cycles and ignores CRES_PF.
// - two pulled-up straps; grounded one picks parallel or serial host ports.
// - each command executes as soon as it is fully received.
// - DAC output updates only when the upper code byte register is written.
// - commands carry even parity over address, data and parity bits, plus the direction bit on the serial ports.
// - serial direction bit high means write, low means read.
// - parity error discards the command and drives acknowledge high.
// - serial acknowledge valid after select rises until select falls again.
// - parallel acknowledge follows stable inputs; write commits with ack low, select low.
// - writing 01101010 to register 0 holds defaults until another code is written.
// - under master reset, bi-level outputs five to eight show undervoltage and power-on.
// - clearing function bit 7 sleeps; registers and port stay, bits 0-6 disabled.
// - enable bits default 1; clearing powers down mux, comparators, amps, DAC, inputs, ADC.
// - function bit 5 set powers down current source; clear routes it to selected channel.
// - monitor bit 6 routes VCC/6 to non-inverting input, ground to inverting.
// - monitor bit 5 routes VEE/6 to inverting input, ground to non-inverting.
// - monitor bits 4 or 3 route +5V or reference /2 to non-inverting, ground inverting.
// - power bits 2..0 are read-only undervoltage flags for VCC, VEE, +5V.
`ifndef HCP_MAP_VH
`define HCP_MAP_VH
`define HCP_REG_MRST 5'h00
`define HCP_REG_FEN 5'h01
`define HCP_REG_PWR 5'h02
`define HCP_REG_DAC_LO 5'h09
`define HCP_REG_DAC_HI 5'h0A
`define HCP_MRST_CODE 8'h6A
`define HCP_FEN_RST 8'hFF
`define HCP_PWR_RST 8'h00
`define HCP_FEN_CHIP 7
`define HCP_FEN_CSRC_DIS 5
`define HCP_PWR_ALT_IREF 7
`define HCP_PWR_MON_VCC 6
`define HCP_PWR_MON_VEE 5
`define HCP_PWR_MON_5V 4
`define HCP_PWR_MON_VREF 3
`define HCP_RC_K 35000
`define HCP_CLK_MHZ 20
`define HCP_SER_BITS 15
`endif

//--- src/hcp_sync.v
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by second stage
`timescale 1ns/10ps
`default_nettype none
module hcp_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;
    always @(posedge clk) begin
        if (!resetn) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- src/hcp_top.v
// Purpose: host port decode, parity check, reset control and power registers
// Assumes: one 20 MHz clock; all host pins sampled through two flops
// Notes: serial frame w/r, a[4:0], d[7:0], p, msb first, sampled on sclk rise
`timescale 1ns/10ps
`default_nettype none
`include "hcp_map.vh"
module hcp_top #(
    parameter CRES_PF = 1000,
    parameter RC_CYC = 700
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // reset pin and mode
    input wire auto_reset_mode,
    input wire reset_pin_n,
    input wire supplies_valid,
    // straps
    input wire strap_spi_n,
    input wire strap_par_n,
    // parallel port
    input wire par_ce_n,
    input wire par_we_n,
    input wire par_oe_n,
    input wire [4:0] par_addr,
    input wire [7:0] par_din,
    output reg [7:0] par_dout,
    output wire par_dout_oe_n,
    input wire parallel_parity_line,
    // serial ports a and b
    input wire spi_a_ss_n,
    input wire spi_a_sclk,
    input wire spi_a_mosi,
    input wire spi_b_ss_n,
    input wire spi_b_sclk,
    input wire spi_b_mosi,
    output reg spi_miso,
    output wire spi_miso_oe_n,
    // acknowledge
    output reg ack_n,
    // analog status in
    input wire uv_vcc,
    input wire uv_vee,
    input wire uv_5v,
    input wire por_enable,
    input wire [7:0] bl_cmp,
    // bi-level outputs 1..8
    output reg [7:0] bilevel_out,
    // power controls out
    output reg chip_awake,
    output reg [6:0] fn_power,
    output reg csrc_on,
    output reg [2:0] amp_route,
    output reg use_alt_iref,
    output reg [9:0] dac_code,
    output reg mrst_active
);
    localparam RC_NS = `HCP_RC_K * CRES_PF / 1000;
    localparam RC_CYCLES = (RC_NS * `HCP_CLK_MHZ + 999) / 1000;
    localparam RT_HOLD = 2'd0;
    localparam RT_COUNT = 2'd1;
    localparam RT_RUN = 2'd2;
    localparam AR_NORM = 3'd0;
    localparam AR_VCC = 3'd1;
    localparam AR_VEE = 3'd2;
    localparam AR_5V = 3'd3;
    localparam AR_VREF = 3'd4;

    function even_ok;
        input [14:0] v;
        begin
            even_ok = ~(^v);
        end
    endfunction

    wire [23:0] s_q;
    // reset to idle pin levels so no false edge follows reset
    hcp_sync #(.W(24), .INIT(24'h1F_4800)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({auto_reset_mode, reset_pin_n, supplies_valid, strap_spi_n, strap_par_n,
            par_ce_n, par_we_n, par_oe_n, parallel_parity_line, spi_a_ss_n, spi_a_sclk,
            spi_a_mosi, spi_b_ss_n, spi_b_sclk, spi_b_mosi, uv_vcc, uv_vee, uv_5v,
            por_enable, par_addr}),
        .q(s_q)
    );
    reg [7:0] din_s1_r, din_s2_r;
    reg [7:0] blc_s1_r, blc_s2_r;
    always @(posedge clk) begin
        if (!resetn) begin
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
            blc_s1_r <= 8'h00;
            blc_s2_r <= 8'h00;
        end else begin
            din_s1_r <= par_din;
            din_s2_r <= din_s1_r;
            blc_s1_r <= bl_cmp;
            blc_s2_r <= blc_s1_r;
        end
    end
    wire s_auto = s_q[23];
    wire s_rstpin_n = s_q[22];
    wire s_supok = s_q[21];
    wire s_strap_spi_n = s_q[20];
    wire s_strap_par_n = s_q[19];
    wire s_ce_n = s_q[18];
    wire s_we_n = s_q[17];
    wire s_oe_n = s_q[16];
    wire s_parity = s_q[15];
    wire s_a_ss_n = s_q[14];
    wire s_a_sclk = s_q[13];
    wire s_a_mosi = s_q[12];
    wire s_b_ss_n = s_q[11];
    wire s_b_sclk = s_q[10];
    wire s_b_mosi = s_q[9];
    wire s_uv_vcc = s_q[8];
    wire s_uv_vee = s_q[7];
    wire s_uv_5v = s_q[6];
    wire s_por = s_q[5];
    wire [4:0] s_addr = s_q[4:0];

    // power-on reset: pin in manual mode, rc delay after supplies in auto mode
    reg [1:0] rt_state_r;
    reg [31:0] rc_cnt_r;
    always @(posedge clk) begin
        if (!resetn) begin
            rt_state_r <= RT_HOLD;
            rc_cnt_r <= 32'h0000_0000;
        end else begin
            case (rt_state_r)
                RT_HOLD: begin
                    rc_cnt_r <= 32'h0000_0000;
                    if (s_auto && s_supok)
                        rt_state_r <= RT_COUNT;
                    else if (!s_auto && s_rstpin_n)
                        rt_state_r <= RT_RUN;
                end
                RT_COUNT: begin
                    if (!s_supok)
                        rt_state_r <= RT_HOLD;
                    else if (rc_cnt_r >= RC_CYC - 1)
                        rt_state_r <= RT_RUN;
                    else
                        rc_cnt_r <= rc_cnt_r + 32'h0000_0001;
                end
                RT_RUN: begin
                    if ((s_auto && !s_supok) || (!s_auto && !s_rstpin_n))
                        rt_state_r <= RT_HOLD;
                end
                default: rt_state_r <= RT_HOLD;
            endcase
        end
    end
    wire por_hold = (rt_state_r != RT_RUN);

    // strap port selection; serial wins only when its strap alone is grounded
    wire sel_ser = !s_strap_spi_n && s_strap_par_n;
    wire sel_par = !s_strap_par_n && s_strap_spi_n;

    // registers
    reg [7:0] fen_r, pwr_r, dac_lo_r;
    reg mrst_r;
    reg cmd_go;
    reg cmd_wr;
    reg [4:0] cmd_addr;
    reg [7:0] cmd_data;
    wire soft_hold = mrst_r || por_hold;
    wire [7:0] pwr_view = {pwr_r[7:3], s_uv_vcc, s_uv_vee, s_uv_5v};

    always @(posedge clk) begin
        if (!resetn || por_hold) begin
            fen_r <= `HCP_FEN_RST;
            pwr_r <= `HCP_PWR_RST;
            dac_lo_r <= 8'h00;
            dac_code <= 10'h000;
            mrst_r <= 1'b0;
        end else if (cmd_go && cmd_wr) begin
            if (cmd_addr == `HCP_REG_MRST) begin
                mrst_r <= (cmd_data == `HCP_MRST_CODE);
            end else if (mrst_r) begin
                fen_r <= `HCP_FEN_RST;
            end else if (cmd_addr == `HCP_REG_FEN) begin
                fen_r <= cmd_data;
            end else if (cmd_addr == `HCP_REG_PWR) begin
                pwr_r <= {cmd_data[7:3], 3'b000};
            end else if (cmd_addr == `HCP_REG_DAC_LO) begin
                dac_lo_r <= cmd_data;
            end else if (cmd_addr == `HCP_REG_DAC_HI) begin
                dac_code <= {cmd_data[1:0], dac_lo_r};
            end
        end else if (mrst_r) begin
            fen_r <= `HCP_FEN_RST;
            pwr_r <= `HCP_PWR_RST;
            dac_lo_r <= 8'h00;
            dac_code <= 10'h000;
        end
    end

    function [7:0] rd_mux;
        input [4:0] a;
        begin
            if (a == `HCP_REG_FEN)
                rd_mux = fen_r;
            else if (a == `HCP_REG_PWR)
                rd_mux = pwr_view;
            else if (a == `HCP_REG_DAC_LO)
                rd_mux = dac_lo_r;
            else if (a == `HCP_REG_DAC_HI)
                rd_mux = {6'b00_0000, dac_code[9:8]};
            else
                rd_mux = 8'h00;
        end
    endfunction

    // parallel port: check on falling select, commit once ack is low
    reg ce_d_r;
    reg par_busy_r;
    wire par_ok = even_ok({1'b0, s_addr, din_s2_r, s_parity});
    wire par_start = sel_par && ce_d_r && !s_ce_n;
    always @(posedge clk) begin
        if (!resetn) begin
            ce_d_r <= 1'b1;
            par_busy_r <= 1'b0;
        end else begin
            ce_d_r <= s_ce_n;
            par_busy_r <= par_start ? 1'b1 : (s_ce_n ? 1'b0 : par_busy_r);
        end
    end
    assign par_dout_oe_n = !(sel_par && !s_ce_n && !s_oe_n && s_we_n);

    // serial port: active port is whichever select is low
    wire ser_ss_n = !s_a_ss_n ? 1'b0 : s_b_ss_n;
    wire ser_sclk = !s_a_ss_n ? s_a_sclk : s_b_sclk;
    wire ser_mosi = !s_a_ss_n ? s_a_mosi : s_b_mosi;
    reg sclk_d_r, ss_d_r;
    reg [14:0] sh_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] miso_sh_r;
    reg wr_bit_r;
    wire sclk_rise = sel_ser && !ser_ss_n && !sclk_d_r && ser_sclk;
    wire sclk_fall = sel_ser && !ser_ss_n && sclk_d_r && !ser_sclk;
    wire ss_rise = sel_ser && !ss_d_r && ser_ss_n;
    wire ss_fall = sel_ser && ss_d_r && !ser_ss_n;
    wire ser_full = (bit_cnt_r == `HCP_SER_BITS);
    wire ser_ok = even_ok(sh_r);
    always @(posedge clk) begin
        if (!resetn) begin
            sclk_d_r <= 1'b0;
            ss_d_r <= 1'b1;
            sh_r <= 15'h0000;
            bit_cnt_r <= 4'h0;
            miso_sh_r <= 8'h00;
            spi_miso <= 1'b0;
            wr_bit_r <= 1'b1;
        end else begin
            sclk_d_r <= ser_sclk;
            ss_d_r <= ser_ss_n;
            if (ss_fall) begin
                bit_cnt_r <= 4'h0;
            end else if (sclk_rise && bit_cnt_r < 4'd15) begin
                sh_r <= {sh_r[13:0], ser_mosi};
                bit_cnt_r <= bit_cnt_r + 4'h1;
                // direction latched once; it moves up the shifter afterwards
                if (bit_cnt_r == 4'h0)
                    wr_bit_r <= ser_mosi;
                if (bit_cnt_r == 4'd5)
                    miso_sh_r <= rd_mux({sh_r[3:0], ser_mosi});
            end
            if (sclk_fall && bit_cnt_r >= 4'd6 && bit_cnt_r < 4'd14) begin
                spi_miso <= miso_sh_r[7];
                miso_sh_r <= {miso_sh_r[6:0], 1'b0};
            end
        end
    end
    // read data driven from the data field through the parity bit of a read frame
    assign spi_miso_oe_n = !(sel_ser && !ser_ss_n && !wr_bit_r && bit_cnt_r >= 4'd6 && bit_cnt_r < 4'd15);

    // command issue and acknowledge
    always @(*) begin
        cmd_go = 1'b0;
        cmd_wr = 1'b0;
        cmd_addr = 5'h00;
        cmd_data = 8'h00;
        if (par_start && par_ok && !s_we_n) begin
            cmd_go = 1'b1;
            cmd_wr = 1'b1;
            cmd_addr = s_addr;
            cmd_data = din_s2_r;
        end else if (ss_rise && ser_full && ser_ok) begin
            cmd_go = 1'b1;
            cmd_wr = sh_r[14];
            cmd_addr = sh_r[13:9];
            cmd_data = sh_r[8:1];
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            ack_n <= 1'b1;
            par_dout <= 8'h00;
        end else begin
            if (par_start) begin
                ack_n <= !par_ok;
                par_dout <= rd_mux(s_addr);
            end else if (ss_rise) begin
                ack_n <= !(ser_full && ser_ok);
            end else if (ss_fall || (par_busy_r && s_ce_n)) begin
                ack_n <= 1'b1;
            end
        end
    end

    // outputs
    wire awake = fen_r[`HCP_FEN_CHIP];
    always @(posedge clk) begin
        if (!resetn) begin
            chip_awake <= 1'b1;
            fn_power <= 7'h7F;
            csrc_on <= 1'b0;
            amp_route <= AR_NORM;
            use_alt_iref <= 1'b0;
            mrst_active <= 1'b0;
            bilevel_out <= 8'h00;
        end else begin
            chip_awake <= awake;
            fn_power <= fen_r[6:0] & {7{awake}};
            csrc_on <= awake && !fen_r[`HCP_FEN_CSRC_DIS];
            use_alt_iref <= pwr_r[`HCP_PWR_ALT_IREF];
            mrst_active <= soft_hold;
            if (pwr_r[`HCP_PWR_MON_VCC])
                amp_route <= AR_VCC;
            else if (pwr_r[`HCP_PWR_MON_VEE])
                amp_route <= AR_VEE;
            else if (pwr_r[`HCP_PWR_MON_5V])
                amp_route <= AR_5V;
            else if (pwr_r[`HCP_PWR_MON_VREF])
                amp_route <= AR_VREF;
            else
                amp_route <= AR_NORM;
            // power-on hold shows the same test view as master reset
            if (soft_hold)
                bilevel_out <= {s_por, s_uv_5v, s_uv_vee, s_uv_vcc, blc_s2_r[3:0]};
            else
                bilevel_out <= blc_s2_r & {8{awake && fen_r[1]}};
        end
    end
endmodule
`default_nettype wire

//--- verification/hcp_host_model.sv
// Purpose: host logic model driving the parallel port and both serial ports
// Assumes: tasks are entered just after a clk rise
// Notes: serial clock and data are shared; the select picks the port
`timescale 1ns/10ps
`default_nettype none
module hcp_host_model (
    // clock
    input wire logic clk,
    // parallel port
    output logic par_ce_n,
    output logic par_we_n,
    output logic par_oe_n,
    output logic [4:0] par_addr,
    output logic [7:0] par_din,
    output logic parallel_parity_line,
    input wire logic [7:0] par_dout,
    // serial ports
    output logic spi_a_ss_n,
    output logic spi_b_ss_n,
    output wire logic spi_a_sclk,
    output wire logic spi_a_mosi,
    output wire logic spi_b_sclk,
    output wire logic spi_b_mosi,
    input wire logic spi_miso,
    // acknowledge
    input wire logic ack_n
);
    logic sck = 1'b0;
    logic mo = 1'b0;
    assign spi_a_sclk = sck;
    assign spi_a_mosi = mo;
    assign spi_b_sclk = sck;
    assign spi_b_mosi = mo;
    initial begin
        par_ce_n = 1'b1;
        par_we_n = 1'b1;
        par_oe_n = 1'b1;
        par_addr = 5'h00;
        par_din = 8'h00;
        parallel_parity_line = 1'b0;
        spi_a_ss_n = 1'b1;
        spi_b_ss_n = 1'b1;
    end
    task automatic par_cycle(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic bad,
                             output logic [7:0] q, output logic ak);
        par_addr <= a;
        par_din <= d;
        parallel_parity_line <= ^{a, d} ^ bad;
        par_we_n <= !wr;
        par_oe_n <= wr;
        repeat (4) @(posedge clk);
        par_ce_n <= 1'b0;
        repeat (8) @(posedge clk);
        q = par_dout;
        ak = ack_n;
        par_ce_n <= 1'b1;
        repeat (2) @(posedge clk);
        // released bus must not keep showing the old value
        par_din <= ~d;
        repeat (4) @(posedge clk);
    endtask
    task automatic spi_frame(input logic prt, input logic w, input logic [4:0] a, input logic [7:0] d,
                             input logic bad, output logic [7:0] q, output logic ak);
        logic [14:0] f;
        f = {w, a, d, ^{w, a, d} ^ bad};
        if (prt)
            spi_b_ss_n <= 1'b0;
        else
            spi_a_ss_n <= 1'b0;
        for (int i = 14; i >= 0; i--) begin
            mo <= f[i];
            repeat (4) @(posedge clk);
            if (i <= 8 && i >= 1)
                q = {q[6:0], spi_miso};
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        spi_a_ss_n <= 1'b1;
        spi_b_ss_n <= 1'b1;
        mo <= ~f[0];
        repeat (8) @(posedge clk);
        ak = ack_n;
    endtask
endmodule
`default_nettype wire

//--- verification/hcp_top_asserts.sv
// Purpose: port-level checks for hcp_top
// Assumes: one clk domain, resetn synchronous active low
// Notes: bound into every hcp_top instance
`timescale 1ns/10ps
`default_nettype none
module hcp_top_asserts #(
    parameter RC_CYC = 700
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins in
    input wire logic supplies_valid,
    input wire logic strap_par_n,
    input wire logic par_ce_n,
    input wire logic par_we_n,
    input wire logic spi_a_ss_n,
    input wire logic spi_b_ss_n,
    input wire logic uv_vcc,
    input wire logic uv_vee,
    input wire logic uv_5v,
    input wire logic por_enable,
    // pins out
    input wire logic par_dout_oe_n,
    input wire logic spi_miso_oe_n,
    input wire logic ack_n,
    input wire logic [7:0] bilevel_out,
    input wire logic chip_awake,
    input wire logic [6:0] fn_power,
    input wire logic csrc_on,
    input wire logic [2:0] amp_route,
    input wire logic mrst_active
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire logic [3:0] tst = {por_enable, uv_5v, uv_vee, uv_vcc};
    wire logic ss_idle = spi_a_ss_n && spi_b_ss_n;
    logic [15:0] sv_cnt_r;
    logic por_done_r;
    // supply-valid cycles up to the first power-on release
    always @(posedge clk) begin
        if (!resetn) begin
            sv_cnt_r <= 16'h0000;
            por_done_r <= 1'b0;
        end else begin
            if (supplies_valid && !por_done_r)
                sv_cnt_r <= sv_cnt_r + 16'h0001;
            if ($fell(mrst_active))
                por_done_r <= 1'b1;
        end
    end
    AST_AUTO_RC: assert property ($fell(mrst_active) && !por_done_r |-> sv_cnt_r >= RC_CYC && sv_cnt_r <= RC_CYC + 8)
        else $error("power-on release outside rc delay");
    AST_SLEEP: assert property (!chip_awake |-> fn_power == 7'h00 && !csrc_on)
        else $error("sleep leaves a function powered");
    AST_MRST_DEF: assert property (mrst_active [*2] |-> chip_awake && fn_power == 7'h7F && amp_route == 3'h0)
        else $error("master reset not holding defaults");
    AST_BLO_TEST: assert property ((mrst_active && $stable(tst)) [*4] |-> bilevel_out[7:4] == tst)
        else $error("test signals missing on bi-level outputs");
    AST_PAR_ACK: assert property ((!strap_par_n && par_ce_n) [*5] |-> ack_n)
        else $error("ack held with select high");
    AST_SER_ACK: assert property ((strap_par_n && ss_idle) [*6] |=> $stable(ack_n))
        else $error("serial ack moved while select high");
    AST_DOUT_OE: assert property (!par_dout_oe_n |-> par_we_n && !strap_par_n)
        else $error("parallel data driven outside a read");
    AST_SPI_QUIET: assert property (!strap_par_n |-> spi_miso_oe_n)
        else $error("serial out driven in parallel mode");
    COV_SLEEP: cover property ($fell(chip_awake));
    COV_MRST: cover property ($rose(mrst_active) && por_done_r);
    COV_SER_ACK: cover property (strap_par_n && $fell(ack_n));
endmodule
bind hcp_top hcp_top_asserts #(.RC_CYC(RC_CYC)) i_chk (.clk, .resetn, .supplies_valid, .strap_par_n, .par_ce_n,
    .par_we_n, .spi_a_ss_n, .spi_b_ss_n, .uv_vcc, .uv_vee, .uv_5v, .por_enable, .par_dout_oe_n, .spi_miso_oe_n,
    .ack_n, .bilevel_out, .chip_awake, .fn_power, .csrc_on, .amp_route, .mrst_active);
`default_nettype wire

//--- verification/tb.sv
// Purpose: self-checking bench for hcp_top
// Assumes: auto reset mode with a short rc count first, manual reset mode later
// Notes: host traffic comes from hcp_host_model
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int RC = 8;
    logic clk, resetn, supplies_valid, strap_spi_n, strap_par_n, uv_vcc, uv_vee, uv_5v, por_enable, ak;
    logic [7:0] q, bl_cmp;
    logic auto_reset_mode, reset_pin_n;
    wire logic par_ce_n, par_we_n, par_oe_n, parallel_parity_line, spi_a_ss_n, spi_a_sclk, spi_a_mosi;
    wire logic spi_b_ss_n, spi_b_sclk, spi_b_mosi, spi_miso, ack_n, chip_awake, csrc_on, use_alt_iref, mrst_active;
    wire logic [4:0] par_addr;
    wire logic [7:0] par_din, par_dout, bilevel_out;
    wire logic [6:0] fn_power;
    wire logic [2:0] amp_route;
    wire logic [9:0] dac_code;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    hcp_top #(.RC_CYC(RC)) i_dut (.clk, .resetn, .auto_reset_mode, .reset_pin_n, .supplies_valid,
        .strap_spi_n, .strap_par_n, .par_ce_n, .par_we_n, .par_oe_n, .par_addr, .par_din, .par_dout,
        .par_dout_oe_n(), .parallel_parity_line, .spi_a_ss_n, .spi_a_sclk, .spi_a_mosi, .spi_b_ss_n,
        .spi_b_sclk, .spi_b_mosi, .spi_miso, .spi_miso_oe_n(), .ack_n, .uv_vcc, .uv_vee, .uv_5v, .por_enable,
        .bl_cmp, .bilevel_out, .chip_awake, .fn_power, .csrc_on, .amp_route, .use_alt_iref, .dac_code,
        .mrst_active);
    hcp_host_model i_host (.clk, .par_ce_n, .par_we_n, .par_oe_n, .par_addr, .par_din, .parallel_parity_line,
        .par_dout, .spi_a_ss_n, .spi_b_ss_n, .spi_a_sclk, .spi_a_mosi, .spi_b_sclk, .spi_b_mosi, .spi_miso, .ack_n);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pw(input logic [4:0] a, input logic [7:0] d);
        i_host.par_cycle(1'b1, a, d, 1'b0, q, ak);
    endtask
    task automatic pr(input logic [4:0] a);
        i_host.par_cycle(1'b0, a, 8'h00, 1'b0, q, ak);
    endtask
    task automatic report_and_stop();
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_por();
        int n;
        n = 0;
        repeat (4) @(posedge clk);
        chk(mrst_active, 1'b1);
        supplies_valid <= 1'b1;
        while (mrst_active !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(n >= RC && n <= RC + 8, 1'b1);
        chk({ack_n, chip_awake, fn_power, csrc_on, amp_route, dac_code}, {2'b11, 7'h7F, 4'h0, 10'h000});
    endtask
    task automatic t_fen();
        i_host.par_cycle(1'b1, 5'h01, 8'h7F, 1'b1, q, ak);
        chk({ak, chip_awake}, 2'b11);
        pw(5'h01, 8'h7F);
        chk({ak, chip_awake, fn_power}, 9'h000);
        for (int b = 0; b < 7; b++) begin
            pw(5'h01, 8'hFF ^ (8'h01 << b));
            chk({fn_power, csrc_on}, {7'h7F ^ (7'h01 << b), b == 5});
        end
        pr(5'h01);
        chk(q, 8'hBF);
    endtask
    task automatic t_pwr();
        uv_vcc <= 1'b1;
        uv_5v <= 1'b1;
        for (int k = 3; k < 7; k++) begin
            pw(5'h02, 8'h01 << k);
            chk(amp_route, 7 - k);
        end
        pw(5'h02, 8'h87);
        pr(5'h02);
        chk({q, use_alt_iref, amp_route}, {8'h85, 4'h8});
    endtask
    task automatic t_dac();
        pw(5'h09, 8'h55);
        chk(dac_code, 10'h000);
        pw(5'h0A, 8'h02);
        chk(dac_code, 10'h255);
    endtask
    task automatic t_mrst();
        por_enable <= 1'b1;
        bl_cmp <= 8'h5A;
        pw(5'h00, 8'h6A);
        pw(5'h01, 8'h00);
        chk({mrst_active, chip_awake, dac_code}, 12'hC00);
        chk(bilevel_out, {por_enable, uv_5v, uv_vee, uv_vcc, 4'hA});
        pw(5'h00, 8'h00);
        chk({mrst_active, fn_power}, 8'h7F);
        chk(bilevel_out, 8'h5A);
    endtask
    task automatic t_man();
        int n;
        n = 0;
        pw(5'h01, 8'h3F);
        auto_reset_mode <= 1'b0;
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk({mrst_active, chip_awake, fn_power}, 9'h1FF);
        reset_pin_n <= 1'b1;
        while (mrst_active !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 3 && n <= 6, 1'b1);
        pw(5'h01, 8'hFE);
        chk(fn_power, 7'h7E);
    endtask
    task automatic t_spi();
        strap_par_n <= 1'b1;
        strap_spi_n <= 1'b0;
        repeat (8) @(posedge clk);
        i_host.spi_frame(1'b0, 1'b1, 5'h01, 8'hFE, 1'b0, q, ak);
        chk({ak, fn_power}, 8'h7E);
        i_host.spi_frame(1'b1, 1'b1, 5'h01, 8'hFF, 1'b1, q, ak);
        chk({ak, fn_power}, 8'hFE);
        i_host.spi_frame(1'b1, 1'b0, 5'h01, 8'h00, 1'b0, q, ak);
        chk({q, fn_power}, {8'hFE, 7'h7E});
        pw(5'h01, 8'h80);
        chk(fn_power, 7'h7E);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        resetn = 1'b0;
        supplies_valid = 1'b0;
        strap_spi_n = 1'b1;
        strap_par_n = 1'b0;
        {uv_vcc, uv_vee, uv_5v, por_enable} = 4'h0;
        auto_reset_mode = 1'b1;
        reset_pin_n = 1'b1;
        bl_cmp = 8'h00;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_por();
        t_fen();
        t_pwr();
        t_dac();
        t_mrst();
        t_man();
        t_spi();
        report_and_stop();
    end
endmodule
`default_nettype wire
